/* File: rtl/segment_lcd_pkg.sv */
package segment_lcd_pkg;

   // Host write port pins, low-active strobes
   typedef struct packed {
      logic chipSelectN;
      logic writeStrobeN;
      logic byteCountResetN;
      logic [7:0] hostDataLines;
   } host_bus_type;

   typedef enum logic [1:0] {
      DUTY_STATIC = 2'h0,
      DUTY_HALF = 2'h1,
      DUTY_THIRD = 2'h2,
      DUTY_QUARTER = 2'h3
   } duty_type;

   typedef struct packed {
      logic readyPortMode;
      logic displayOff;
      duty_type driveMode;
      duty_type dataDisplayMode;
   } mode_type;

   typedef enum logic [1:0] {
      ST_COLLECT = 2'h1,
      ST_BUSY = 2'h2
   } state_type;

   // Command type in the top two bits of the first unit
   localparam logic [1:0] CMD_DISPLAY = 2'h0;
   localparam logic [1:0] CMD_BIT = 2'h1;
   localparam logic [1:0] CMD_MODE = 2'h2;
   localparam logic [1:0] CMD_SKIP = 2'h3;

   // Field positions in the assembled 16-bit command word
   localparam int FLD_TYPE_LSB = 14;
   localparam int FLD_ADDR_LSB = 8;
   localparam int FLD_ADDR_W = 6;
   localparam int FLD_BIT_DATA = 7;
   localparam int FLD_READY = 11;
   localparam int FLD_DRIVE_LSB = 8;
   localparam int FLD_OFF = 2;
   localparam int FLD_DISP_LSB = 0;

   localparam int WIDE_UNITS = 2;
   localparam int NARROW_UNITS = 4;
   localparam int WIDE_SEGS = 51;
   localparam int NARROW_SEGS = 64;
   localparam int WIDE_COMS = 4;
   localparam int NARROW_COMS = 1;

   localparam mode_type MODE_RESET = '{readyPortMode: 1'b0, displayOff: 1'b1,
      driveMode: DUTY_STATIC, dataDisplayMode: DUTY_STATIC};

   // Busy periods, in tenths of an oscillator clock
   localparam int OSC_PERIOD_NS = 10000;
   localparam int MCLK_PERIOD_NS = 5;
   localparam int BUSY_SHORT_TENTHS = 35;
   localparam int BUSY_LONG_TENTHS = 105;
   localparam int BUSY_SHORT_CYCLES = (BUSY_SHORT_TENTHS * OSC_PERIOD_NS) / (10 * MCLK_PERIOD_NS);
   localparam int BUSY_LONG_CYCLES = (BUSY_LONG_TENTHS * OSC_PERIOD_NS) / (10 * MCLK_PERIOD_NS);
   localparam int BUSY_CNT_W = 16;

endpackage : segment_lcd_pkg

/* File: rtl/segment_lcd_write_decoder.sv */
`timescale 1ns/100ps

// What this block does
// - Wide variant: single-bit write plus digit writes for static, half, third, quarter.
// - Digit writes to last partial digit keep only bits that exist in RAM.
// - Wide single-bit write: data bit, 6-bit segment, 2-bit common; one bit changes.
// - Narrow digit write uses four 4-bit transfers carrying address and 8-bit pattern.
// - Wide drive modes static, half, third, quarter selected by drive mode field; narrow always static.
// - After a full group ready goes low while processing in ready mode 1; host waits.
// - Mode settings independent; single-bit writes ignore data display mode.
// - Display off stops driving the panel so it is blank.
// - Second byte bits 1-0 display mode, bit 2 off; drive field same codes.
// - Off bit 1 blanks, 0 enables; sync pulse forces it to 1.
// - Ready mode 0: low only with select and reset low; sync clears it.
// - Wide first byte with bits 7 and 6 high is ignored, counter stays.
// - Narrow first nibble with bits 3 and 2 high is ignored.
// - Unit position known only by arrival order via internal counter.
// - Select and byte-count reset low together clear counter, data untouched.
// - Data port behaves like a static RAM write port.
// - Narrow single-bit write: data bit and 6-bit segment, one bit changes.
// - Data taken on write strobe rising edge, only while select low.
// - Ready low at most 3.5 clocks short commands, 10.5 clocks digit writes, plus any time standby holds the busy count.
// - Sync high resets drive timing and blanks the display.
module segment_lcd_write_decoder #(
   parameter bit NARROW = 1'b0,
   parameter int SEG_COUNT = NARROW ? segment_lcd_pkg::NARROW_SEGS : segment_lcd_pkg::WIDE_SEGS,
   parameter int COM_COUNT = NARROW ? segment_lcd_pkg::NARROW_COMS : segment_lcd_pkg::WIDE_COMS,
   parameter int BUSY_SHORT = segment_lcd_pkg::BUSY_SHORT_CYCLES,
   parameter int BUSY_LONG = segment_lcd_pkg::BUSY_LONG_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire segment_lcd_pkg::host_bus_type hostBus,
   input wire logic syncIn,
   input wire logic standbyRequest,
   input wire logic readyPinIn,
   output logic readyPinOut,
   output logic readyPinOe,
   output segment_lcd_pkg::mode_type modeState,
   output logic displayBlank,
   output logic timingReset,
   output logic busy,
   output logic [COM_COUNT*SEG_COUNT-1:0] displayRam
);
   import segment_lcd_pkg::*;

   localparam int UNITS = NARROW ? NARROW_UNITS : WIDE_UNITS;
   localparam int UNIT_W = NARROW ? 4 : 8;
   localparam int CELLS = COM_COUNT * SEG_COUNT;

   // Two-flop synchronisers for the host bus, sync and standby inputs; readyPinIn is used unsynchronised
   logic [12:0] pinMeta_reg;
   logic [12:0] pinSync_reg;
   always_ff @(posedge mclk) begin
      if (rst) begin
         pinMeta_reg <= 13'h1C00;
         pinSync_reg <= 13'h1C00;
      end else begin
         pinMeta_reg <= {hostBus, syncIn, standbyRequest};
         pinSync_reg <= pinMeta_reg;
      end
   end

   host_bus_type busS;
   logic syncS;
   logic standbyS;
   assign busS = pinSync_reg[12:2];
   assign syncS = pinSync_reg[1];
   assign standbyS = pinSync_reg[0];

   logic strobeLast_reg;
   always_ff @(posedge mclk) begin
      if (rst) begin
         strobeLast_reg <= 1'b1;
      end else begin
         strobeLast_reg <= busS.writeStrobeN;
      end
   end

   logic counterClear;
   logic unitTaken;
   logic [UNIT_W-1:0] unitData;
   logic skipUnit;
   assign counterClear = !busS.chipSelectN && !busS.byteCountResetN;
   assign unitData = busS.hostDataLines[UNIT_W-1:0];
   assign skipUnit = (unitData[UNIT_W-1 -: 2] == CMD_SKIP);

   state_type state_reg;
   state_type state_next;
   logic [1:0] count_reg;
   logic [15:0] word_reg;
   logic [BUSY_CNT_W-1:0] busyCnt_reg;
   mode_type mode_reg;
   logic [CELLS-1:0] ram_reg;

   // Rising strobe edge, select low, idle, not in standby and not being reset
   assign unitTaken = !strobeLast_reg && busS.writeStrobeN && !busS.chipSelectN
      && !counterClear && !standbyS && (state_reg == ST_COLLECT);

   logic groupDone;
   logic [15:0] wordFull;
   assign groupDone = unitTaken && (count_reg == 2'(UNITS - 1)) && !(count_reg == 2'h0 && skipUnit);
   assign wordFull = NARROW ? {word_reg[11:0], 4'(unitData)} : {word_reg[7:0], 8'(unitData)};

   // Byte counter: position known only from arrival order
   always_ff @(posedge mclk) begin
      if (rst || syncS) begin
         count_reg <= 2'h0;
      end else if (counterClear) begin
         count_reg <= 2'h0;
      end else if (unitTaken) begin
         if (count_reg == 2'h0 && skipUnit) begin
            count_reg <= 2'h0;
         end else if (count_reg == 2'(UNITS - 1)) begin
            count_reg <= 2'h0;
         end else begin
            count_reg <= count_reg + 2'h1;
         end
      end
   end

   // Command word assembly, first unit lands in the top bits
   always_ff @(posedge mclk) begin
      if (rst) begin
         word_reg <= 16'h0000;
      end else if (unitTaken) begin
         word_reg <= wordFull;
      end
   end

   logic [1:0] cmdType;
   assign cmdType = word_reg[FLD_TYPE_LSB +: 2];

   // Busy phase control
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= ST_COLLECT;
      end else begin
         state_reg <= state_next;
      end
   end

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_COLLECT: begin
            if (groupDone) begin
               state_next = ST_BUSY;
            end
         end
         ST_BUSY: begin
            if (busyCnt_reg == BUSY_CNT_W'(1) && !standbyS) begin
               state_next = ST_COLLECT;
            end
         end
      endcase
   end

   // Busy length: digit update is the long case; standby suspends it
   always_ff @(posedge mclk) begin
      if (rst) begin
         busyCnt_reg <= BUSY_CNT_W'(0);
      end else if (groupDone) begin
         if (wordFull[FLD_TYPE_LSB +: 2] == CMD_DISPLAY) begin
            busyCnt_reg <= BUSY_CNT_W'(BUSY_LONG);
         end else begin
            busyCnt_reg <= BUSY_CNT_W'(BUSY_SHORT);
         end
      end else if (state_reg == ST_BUSY && !standbyS && busyCnt_reg != BUSY_CNT_W'(0)) begin
         busyCnt_reg <= busyCnt_reg - BUSY_CNT_W'(1);
      end
   end

   logic applyNow;
   assign applyNow = (state_reg == ST_BUSY) && (busyCnt_reg == BUSY_CNT_W'(1)) && !standbyS;

   // Mode latch, taken at the end of the busy period
   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_reg <= MODE_RESET;
      end else if (syncS) begin
         mode_reg.displayOff <= 1'b1;
         mode_reg.readyPortMode <= 1'b0;
      end else if (applyNow && cmdType == CMD_MODE) begin
         mode_reg.readyPortMode <= word_reg[FLD_READY];
         mode_reg.displayOff <= word_reg[FLD_OFF];
         if (NARROW) begin
            mode_reg.driveMode <= DUTY_STATIC;
            mode_reg.dataDisplayMode <= DUTY_STATIC;
         end else begin
            mode_reg.driveMode <= duty_type'(word_reg[FLD_DRIVE_LSB +: 2]);
            mode_reg.dataDisplayMode <= duty_type'(word_reg[FLD_DISP_LSB +: 2]);
         end
      end
   end

   // Per-cell write mask and value for the pending command
   logic [CELLS-1:0] writeMask;
   logic [CELLS-1:0] writeValue;
   always_comb begin
      int digit;
      int spd;
      int cpd;
      int segment_line;
      int common_line;
      digit = int'(word_reg[FLD_ADDR_LSB +: FLD_ADDR_W]);
      spd = 8;
      cpd = 1;
      segment_line = 0;
      common_line = 0;
      writeMask = '0;
      writeValue = '0;
      unique case (mode_reg.dataDisplayMode)
         DUTY_STATIC: begin
            spd = 8;
            cpd = 1;
         end
         DUTY_HALF: begin
            spd = 4;
            cpd = 2;
         end
         DUTY_THIRD: begin
            spd = 3;
            cpd = 3;
         end
         DUTY_QUARTER: begin
            spd = 2;
            cpd = 4;
         end
      endcase
      if (cmdType == CMD_DISPLAY) begin
         for (int k = 0; k < 8; k++) begin
            segment_line = digit * spd + k / cpd;
            common_line = k % cpd;
            if (segment_line < SEG_COUNT && common_line < COM_COUNT) begin
               writeMask[common_line * SEG_COUNT + segment_line] = 1'b1;
               writeValue[common_line * SEG_COUNT + segment_line] = word_reg[k];
            end
         end
      end else if (cmdType == CMD_BIT) begin
         segment_line = digit;
         common_line = NARROW ? 0 : int'(word_reg[1:0]);
         if (segment_line < SEG_COUNT) begin
            writeMask[common_line * SEG_COUNT + segment_line] = 1'b1;
            writeValue[common_line * SEG_COUNT + segment_line] = word_reg[FLD_BIT_DATA];
         end
      end
   end

   // Display RAM, one flop per cell
   genvar c;
   generate
      for (c = 0; c < CELLS; c++) begin : gCell
         always_ff @(posedge mclk) begin
            if (rst) begin
               ram_reg[c] <= 1'b0;
            end else if (applyNow && writeMask[c]) begin
               ram_reg[c] <= writeValue[c];
            end
         end
      end
   endgenerate

   // Ready pin drives low only; release lets the pull-up take it high
   logic readyLow;
   assign readyLow = (state_reg == ST_BUSY)
      && (mode_reg.readyPortMode || (!busS.chipSelectN && !busS.byteCountResetN));

   assign readyPinOut = 1'b0;
   assign readyPinOe = readyLow;
   assign busy = (state_reg == ST_BUSY) && readyPinIn | (state_reg == ST_BUSY);
   assign modeState = mode_reg;
   assign displayBlank = mode_reg.displayOff || syncS || standbyS;
   assign timingReset = syncS;
   assign displayRam = ram_reg;

endmodule : segment_lcd_write_decoder

/* File: sim/segment_lcd_write_decoder_chk.sv */
`timescale 1ns/100ps
module segment_lcd_write_decoder_chk #(
   parameter int SEG_COUNT = 51,
   parameter int COM_COUNT = 4,
   parameter int BUSY_SHORT = 5,
   parameter int BUSY_LONG = 12
) (
   input wire logic mclk,
   input wire logic rst,
   input wire segment_lcd_pkg::host_bus_type hostBus,
   input wire logic syncIn,
   input wire logic standbyRequest,
   input wire logic readyPinIn,
   input wire logic readyPinOut,
   input wire logic readyPinOe,
   input wire segment_lcd_pkg::mode_type modeState,
   input wire logic displayBlank,
   input wire logic timingReset,
   input wire logic busy,
   input wire logic [COM_COUNT*SEG_COUNT-1:0] displayRam
);
   import segment_lcd_pkg::*;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   int busyLen;
   always_ff @(posedge mclk) begin
      if (rst || !busy) busyLen <= 0;
      else busyLen <= busyLen + 1;
   end
   a_pin_low: assert property (readyPinOut == 1'b0) else $error("ready driven high");
   a_oe_bus_mode: assert property ((hostBus.chipSelectN [*4]) ##0 !modeState.readyPortMode |-> !readyPinOe)
      else $error("ready low with select high");
   a_oe_port_mode: assert property (busy && modeState.readyPortMode |-> readyPinOe)
      else $error("ready not low while busy");
   a_oe_only_busy: assert property (readyPinOe |-> busy) else $error("ready low when idle");
   a_busy_len: assert property ($fell(busy) |-> busyLen inside {[BUSY_SHORT:BUSY_SHORT + 1],
      [BUSY_LONG:BUSY_LONG + 1]}) else $error("busy length wrong");
   a_sync_mode: assert property (syncIn [*5] |=> modeState.displayOff && !modeState.readyPortMode)
      else $error("sync did not reset mode");
   a_sync_blank: assert property (syncIn [*3] |=> displayBlank && timingReset)
      else $error("sync did not blank");
   a_off_blanks: assert property (modeState.displayOff |-> displayBlank) else $error("off not blank");
   a_ram_quiet: assert property (!$past(busy) |-> $stable(displayRam)) else $error("ram changed");
   c_port: cover property ($rose(busy) && modeState.readyPortMode);
   c_bus: cover property ($rose(busy) && !modeState.readyPortMode);
   c_sync: cover property ($rose(timingReset));
endmodule : segment_lcd_write_decoder_chk

/* File: sim/lcd_host_model.sv */
`timescale 1ns/100ps
module lcd_host_model (
   input wire logic mclk,
   input wire logic busy,
   input wire logic readyPinOe,
   output segment_lcd_pkg::host_bus_type hostBus,
   output logic readyPinIn
);
   import segment_lcd_pkg::*;
   // Pull-up on the open-drain ready line
   assign readyPinIn = !readyPinOe;
   initial hostBus = '{1'b0, 1'b1, 1'b1, 8'h00};
   task automatic unit(input logic [7:0] d);
      @(negedge mclk);
      hostBus.hostDataLines = d;
      hostBus.writeStrobeN = 1'b0;
      repeat (3) @(negedge mclk);
      hostBus.writeStrobeN = 1'b1;
      repeat (4) @(negedge mclk);
      hostBus.hostDataLines = ~d;
   endtask : unit
   task automatic group(input logic [7:0] b0, input logic [7:0] b1, input logic park);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      hostBus.chipSelectN = 1'b0;
      unit(b0);
      unit(b1);
      hostBus.chipSelectN = park;
   endtask : group
   task automatic resync;
      hostBus.chipSelectN = 1'b0;
      hostBus.byteCountResetN = 1'b0;
      repeat (4) @(negedge mclk);
      hostBus.byteCountResetN = 1'b1;
   endtask : resync
endmodule : lcd_host_model

/* File: sim/tb.sv */
`timescale 1ns/100ps
module tb;
   import segment_lcd_pkg::*;
   localparam int SEGS = WIDE_SEGS;
   localparam int CELLS = WIDE_COMS * WIDE_SEGS;
   localparam int LAST_AD [4] = '{6, 12, 16, 25};
   typedef struct packed {mode_type m; logic [CELLS-1:0] r;} note_type;
   logic mclk, rst, syncIn, standbyRequest, readyPinIn, readyPinOut, readyPinOe;
   logic displayBlank, timingReset, busy, wasBusy;
   host_bus_type hostBus;
   mode_type modeState, expMode;
   logic [CELLS-1:0] displayRam, expRam;
   note_type notes[$];
   note_type cur;
   int mismatches, checkCount;
   segment_lcd_write_decoder #(.BUSY_SHORT(5), .BUSY_LONG(12)) dut (.mclk(mclk),
      .rst(rst), .hostBus(hostBus), .syncIn(syncIn), .standbyRequest(standbyRequest),
      .readyPinIn(readyPinIn), .readyPinOut(readyPinOut), .readyPinOe(readyPinOe),
      .modeState(modeState), .displayBlank(displayBlank), .timingReset(timingReset),
      .busy(busy), .displayRam(displayRam));
   lcd_host_model host (.mclk(mclk), .busy(busy), .readyPinOe(readyPinOe), .hostBus(hostBus),
      .readyPinIn(readyPinIn));
   task automatic check(input logic [CELLS-1:0] seen, input logic [CELLS-1:0] want);
      checkCount++;
      if (seen !== want) begin
         mismatches++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask : check
   task automatic summarize;
      $display("mismatches %0d checks %0d", mismatches, checkCount);
      if (mismatches == 0 && checkCount > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   task automatic setMode(input logic [1:0] d, input logic off, input logic rdy, input logic pk);
      expMode = '{rdy, off, duty_type'(d), duty_type'(d)};
      notes.push_back('{expMode, expRam});
      host.group({4'h8, rdy, 1'b0, d}, {5'h00, off, d}, pk);
   endtask : setMode
   task automatic digit(input logic [5:0] a, input logic [7:0] p, input logic pk);
      int cpd, spd, segment_line;
      cpd = int'(expMode.dataDisplayMode) + 1;
      spd = (cpd == 1) ? 8 : (cpd == 2) ? 4 : (cpd == 3) ? 3 : 2;
      for (int k = 0; k < 8; k++) begin
         segment_line = int'(a) * spd + k / cpd;
         if (segment_line < SEGS) expRam[(k % cpd) * SEGS + segment_line] = p[k];
      end
      notes.push_back('{expMode, expRam});
      host.group({2'b00, a}, p, pk);
   endtask : digit
   task automatic bitWrite(input logic [5:0] s, input logic [1:0] c, input logic v);
      expRam[int'(c) * SEGS + int'(s)] = v;
      notes.push_back('{expMode, expRam});
      host.group({2'b01, s}, {v, 5'h00, c}, 1'b0);
   endtask : bitWrite
   always @(negedge mclk) begin
      if (wasBusy === 1'b1 && busy === 1'b0) begin
         if (notes.size() == 0) begin
            mismatches++;
         end else begin
            cur = notes.pop_front();
            check(CELLS'(modeState), CELLS'(cur.m));
            check(displayRam, cur.r);
         end
      end
      wasBusy = busy;
   end
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      summarize();
   end
   initial begin
      {rst, syncIn, standbyRequest, wasBusy, expRam} = {1'b1, 3'b000, {CELLS{1'b0}}};
      {mismatches, checkCount, expMode} = {32'd0, 32'd0, MODE_RESET};
      void'($urandom(15677));
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      check(CELLS'(modeState), CELLS'(MODE_RESET));
      check(CELLS'(displayBlank), CELLS'(1'b1));
      for (int d = 0; d < 4; d++) begin
         setMode(2'(d), d[0], ~d[0], d[1]);
         digit(6'(LAST_AD[d]), 8'($urandom), 1'($urandom));
         digit(6'($urandom % LAST_AD[d]), 8'($urandom), 1'($urandom));
         bitWrite(6'($urandom % SEGS), 2'($urandom), 1'($urandom));
      end
      host.unit(8'hC0 | 8'($urandom % 64));
      bitWrite(6'd50, 2'd3, 1'b1);
      // Cut group, then two skip bytes: the first completes the bit write
      host.unit(8'h45);
      expRam[SEGS + 5] = 1'b1;
      notes.push_back('{expMode, expRam});
      host.unit(8'hC5);
      host.unit(8'hC0);
      host.unit(8'h45);
      host.resync();
      bitWrite(6'($urandom % SEGS), 2'($urandom), 1'b1);
      host.hostBus.chipSelectN = 1'b1;
      host.unit(8'h47);
      host.unit(8'h80);
      bitWrite(6'd0, 2'd0, 1'b1);
      syncIn = 1'b1;
      repeat (6) @(negedge mclk);
      syncIn = 1'b0;
      repeat (4) @(negedge mclk);
      expMode.displayOff = 1'b1;
      expMode.readyPortMode = 1'b0;
      check(CELLS'(modeState), CELLS'(expMode));
      check(CELLS'(displayBlank), CELLS'(1'b1));
      // Standby must refuse a byte, else the next group pairs wrongly
      standbyRequest = 1'b1;
      repeat (4) @(negedge mclk);
      check(CELLS'(displayBlank), CELLS'(1'b1));
      host.unit(8'h40);
      standbyRequest = 1'b0;
      repeat (4) @(negedge mclk);
      bitWrite(6'd9, 2'd1, 1'b1);
      repeat (40) @(negedge mclk);
      summarize();
   end
endmodule : tb
bind segment_lcd_write_decoder segment_lcd_write_decoder_chk #(.SEG_COUNT(SEG_COUNT),
   .COM_COUNT(COM_COUNT), .BUSY_SHORT(BUSY_SHORT), .BUSY_LONG(BUSY_LONG)) chk (.mclk(mclk),
   .rst(rst), .hostBus(hostBus), .syncIn(syncIn), .standbyRequest(standbyRequest),
   .readyPinIn(readyPinIn), .readyPinOut(readyPinOut), .readyPinOe(readyPinOe),
   .modeState(modeState), .displayBlank(displayBlank), .timingReset(timingReset),
   .busy(busy), .displayRam(displayRam));
